// [rtsm_defines.vh]
// Constants for the terminal status and memory map block.
// Assumes a 50 MHz core clock and a memory backend that answers requests with an active-low grant.
//
// Behaviour
// RULE1: Message memory is 2K x 16, one 32-word buffer per subaddress and direction.
// RULE2: All configuration comes from static input pins, no programmable registers.
// RULE3: Split RAM: receive half when top address bit is 0, transmit when 1; the code's transmit prefix 6'h1F leaves address bit 10 at 0.
// RULE4: Integrator ties loopback subaddress select low with split RAM halves.
// RULE5: Command value is driven and address latch strobe pulsed for external remapping.
// RULE6: A 7-bit interrupt vector holds the subaddress and the direction bit.
// RULE7: A vector latch strobe pulses so external logic can extend the vector.
// RULE8: Status word bits 15 to 11 equal the terminal address pins.
// RULE9: Status bit 10 is set when a message error is detected.
// RULE10: Status bits 9, 7 to 5 and 1 are always zero.
// RULE11: Status bit 8 follows the service request pin.
// RULE12: Status bit 4 is set when a broadcast message was received.
// RULE13: Status bit 3 follows the terminal busy pin.
// RULE14: Status bit 2 follows the subsystem flag pin.
// RULE15: Status bit 0 follows terminal flag, forced low while inhibited by mode code.
// RULE16: Command and transfer status words stored at prefix then subaddress.
// RULE17: Each memory access raises request low, waits for grant, then releases.
// RULE18: Status inputs are sampled once at assembly and held during transmission.
`ifndef RTSM_DEFINES_VH
`define RTSM_DEFINES_VH

`define RTSM_ADDR_W        11
`define RTSM_PREFIX_RX     6'h00
`define RTSM_PREFIX_TX     6'h1F
`define RTSM_TOP_BIT       10
`define RTSM_SW_ADDR_LSB   11
`define RTSM_SW_MERR       10
`define RTSM_SW_SREQ       8
`define RTSM_SW_BCST       4
`define RTSM_SW_BUSY       3
`define RTSM_SW_SSF        2
`define RTSM_SW_TERMINAL_FLAG_IN      0
`define RTSM_CLK_MHZ       50
`define RTSM_GNT_TMO_NS    12000
// Grant wait of 12 us at the 50 MHz core clock, sized to the timer width.
`define RTSM_GNT_TMO_CYC   10'h258
`define RTSM_TMO_W         10

`endif

// [rtsm_status_map.v]
// Status word assembly, command/status word storage, address mapper and vector strobes.
// Assumes a transfer sequencer issues one-cycle start/end pulses and holds cmd/data inputs stable.
//
`timescale 1ns/100ps
`include "rtsm_defines.vh"

module rtsm_status_map (
  // Clock and reset
  input  wire        clk_in,
  input  wire        srst_in,
  // Static configuration pins
  input  wire [4:0]  terminal_address_in, // see RULE2
  input  wire        loopback_subaddress_select_in,
  input  wire        service_request_in,
  input  wire        terminal_busy_in,
  input  wire        subsystem_flag_in,
  input  wire        terminal_flag_in,
  // Transfer sequencer
  input  wire        xfer_start_in,
  input  wire        xfer_end_in,
  input  wire [15:0] command_word_in,
  input  wire [15:0] transfer_status_word_in,
  input  wire        message_error_in,
  input  wire        broadcast_in,
  input  wire        inhibit_terminal_flag_in_in,
  input  wire        status_load_in,
  // Memory backend
  input  wire        memory_grant_n_in,
  output reg         memory_request_n_out,
  output reg         mem_write_out,
  output reg  [10:0] mem_addr_out,
  output reg  [15:0] mem_wdata_out,
  output reg         mem_timeout_out,
  // Address mapper and vector extension
  output reg  [15:0] command_value_out,
  output reg         address_latch_strobe_out,
  output reg         vector_latch_strobe_out,
  output reg  [6:0]  int_vector_out,
  output reg         int_req_out,
  // Status word
  output reg  [15:0] status_word_out,
  output reg         status_valid_out
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REQ  = 2'b01;
  localparam [1:0] ST_ACC  = 2'b10;

  localparam [`RTSM_TMO_W-1:0] TMO_CYC = `RTSM_GNT_TMO_CYC;

  localparam [`RTSM_TMO_W-1:0] TMO_ZERO = {`RTSM_TMO_W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Memory sequencer state and its next values.
  reg [1:0]             state_r;
  reg [1:0]             state_nxt;
  reg                   pend_cmd_r;
  reg                   pend_cmd_nxt;
  reg                   pend_tsw_r;
  reg                   pend_tsw_nxt;
  reg                   cur_tsw_r;
  reg                   cur_tsw_nxt;
  reg [`RTSM_TMO_W-1:0] tmo_r;
  reg [`RTSM_TMO_W-1:0] tmo_nxt;
  reg                   req_n_nxt;
  reg                   write_nxt;
  reg [10:0]            addr_nxt;
  reg [15:0]            wdata_nxt;
  reg                   timeout_nxt;

  // Command capture and interrupt vector state.
  reg [15:0]            cmd_hold_r;
  reg [15:0]            cmd_hold_nxt;
  reg                   bcst_seen_r;
  reg                   bcst_seen_nxt;
  reg [15:0]            cmd_value_nxt;
  reg [6:0]             vector_nxt;
  reg                   int_req_nxt;

  // Status word assembly.
  reg [15:0]            status_nxt;
  wire [4:0]            sw_addr;
  wire                  sw_merr;
  wire                  sw_sreq;
  wire                  sw_bcst;
  wire                  sw_busy;
  wire                  sw_ssf;
  wire                  sw_terminal_flag_in;

  // Shared address and timer decodes.
  wire [10:0]           word_addr;
  wire                  tmo_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // The loopback select only moves data buffers, which this block never addresses.
  // Command and transfer status words keep their place, so the input is left unread here.

  // Direction picks the 6-bit prefix ahead of the subaddress.
  assign word_addr = {(cmd_hold_r[10] ? `RTSM_PREFIX_TX : `RTSM_PREFIX_RX), cmd_hold_r[9:5]}; // see RULE16

  // The grant timer counts down to zero while the request waits.
  assign tmo_expired = (tmo_r == TMO_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // Command capture, mapper strobe and interrupt vector.

  always @* begin
    cmd_hold_nxt  = cmd_hold_r;
    cmd_value_nxt = command_value_out;
    vector_nxt    = int_vector_out;
    int_req_nxt   = int_req_out;
    bcst_seen_nxt = bcst_seen_r;
    if (xfer_start_in) begin
      cmd_hold_nxt  = command_word_in;
      cmd_value_nxt = command_word_in; // see RULE5
      bcst_seen_nxt = broadcast_in;    // see RULE12
    end
    // The vector settles with its strobe so external logic latches a stable value.
    if (xfer_end_in) begin
      vector_nxt  = {1'b0, cmd_hold_r[10], cmd_hold_r[9:5]}; // see RULE6
      int_req_nxt = 1'b1;
    end else if (xfer_start_in) begin
      int_req_nxt = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      cmd_hold_r               <= 16'h0000;
      command_value_out        <= 16'h0000;
      address_latch_strobe_out <= 1'b0;
      vector_latch_strobe_out  <= 1'b0;
      int_vector_out           <= 7'h00;
      int_req_out              <= 1'b0;
      bcst_seen_r              <= 1'b0;
    end else begin
      cmd_hold_r               <= cmd_hold_nxt;
      command_value_out        <= cmd_value_nxt;
      address_latch_strobe_out <= xfer_start_in; // see RULE5
      vector_latch_strobe_out  <= xfer_end_in;   // see RULE7
      int_vector_out           <= vector_nxt;
      int_req_out              <= int_req_nxt;
      bcst_seen_r              <= bcst_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word, sampled once per load and held during transmission.
  // Sampling once keeps pin changes during transmission from tearing the word.

  assign sw_addr  = terminal_address_in;                  // see RULE8
  assign sw_merr  = message_error_in;                     // see RULE9
  assign sw_sreq  = service_request_in;                   // see RULE11
  // A broadcast seen at the start still counts if the sequencer drops the level before the load.
  assign sw_bcst  = bcst_seen_r | broadcast_in;           // see RULE12
  assign sw_busy  = terminal_busy_in;                     // see RULE13
  assign sw_ssf   = subsystem_flag_in;                    // see RULE14
  // The inhibit mode code only masks the flag; the pin itself is left alone.
  assign sw_terminal_flag_in = terminal_flag_in & ~inhibit_terminal_flag_in_in; // see RULE15

  always @* begin
    status_nxt = status_word_out;
    if (status_load_in) begin // see RULE18
      status_nxt                             = 16'h0000; // see RULE10
      status_nxt[15:`RTSM_SW_ADDR_LSB]       = sw_addr;
      status_nxt[`RTSM_SW_MERR]              = sw_merr;
      status_nxt[`RTSM_SW_SREQ]              = sw_sreq;
      status_nxt[`RTSM_SW_BCST]              = sw_bcst;
      status_nxt[`RTSM_SW_BUSY]              = sw_busy;
      status_nxt[`RTSM_SW_SSF]               = sw_ssf;
      status_nxt[`RTSM_SW_TERMINAL_FLAG_IN]             = sw_terminal_flag_in;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      status_word_out  <= 16'h0000;
      status_valid_out <= 1'b0;
    end else begin
      status_word_out  <= status_nxt;
      status_valid_out <= status_load_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending writes of command word and transfer status word.
  // A start or end that lands during an access stays pending and wins over the clear.

  always @* begin
    pend_cmd_nxt = pend_cmd_r;
    pend_tsw_nxt = pend_tsw_r;
    if (state_r == ST_ACC) begin
      if (cur_tsw_r)
        pend_tsw_nxt = 1'b0;
      else
        pend_cmd_nxt = 1'b0;
    end
    if (xfer_start_in)
      pend_cmd_nxt = 1'b1;
    if (xfer_end_in)
      pend_tsw_nxt = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant timer.
  // It ends a stuck backend access so later transfers still get their writes.

  always @* begin
    tmo_nxt = tmo_r;
    if (state_r == ST_IDLE)
      tmo_nxt = TMO_CYC;
    else if (state_r == ST_REQ && !tmo_expired)
      tmo_nxt = tmo_r - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory write datapath.

  always @* begin
    addr_nxt  = mem_addr_out;
    wdata_nxt = mem_wdata_out;
    // Address and data move only when the grant is taken, so they stand through the write.
    if (state_r == ST_REQ && !memory_grant_n_in) begin
      addr_nxt  = word_addr; // see RULE1
      wdata_nxt = cur_tsw_r ? transfer_status_word_in : cmd_hold_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory request sequencer; the command word goes first when both are pending.

  always @* begin
    state_nxt   = state_r;
    cur_tsw_nxt = cur_tsw_r;
    req_n_nxt   = memory_request_n_out;
    write_nxt   = 1'b0;
    timeout_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pend_cmd_r || pend_tsw_r) begin
          cur_tsw_nxt = ~pend_cmd_r;
          req_n_nxt   = 1'b0; // see RULE17
          state_nxt   = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!memory_grant_n_in) begin
          write_nxt = 1'b1;
          state_nxt = ST_ACC;
        end else if (tmo_expired) begin
          req_n_nxt   = 1'b1;
          timeout_nxt = 1'b1;
          state_nxt   = ST_ACC;
        end
      end
      ST_ACC: begin
        req_n_nxt = 1'b1; // see RULE17
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      state_r              <= ST_IDLE;
      pend_cmd_r           <= 1'b0;
      pend_tsw_r           <= 1'b0;
      cur_tsw_r            <= 1'b0;
      tmo_r                <= TMO_ZERO;
      memory_request_n_out <= 1'b1;
      mem_write_out        <= 1'b0;
      mem_addr_out         <= 11'h000;
      mem_wdata_out        <= 16'h0000;
      mem_timeout_out      <= 1'b0;
    end else begin
      state_r              <= state_nxt;
      pend_cmd_r           <= pend_cmd_nxt;
      pend_tsw_r           <= pend_tsw_nxt;
      cur_tsw_r            <= cur_tsw_nxt;
      tmo_r                <= tmo_nxt;
      memory_request_n_out <= req_n_nxt;
      mem_write_out        <= write_nxt;
      mem_addr_out         <= addr_nxt;
      mem_wdata_out        <= wdata_nxt;
      mem_timeout_out      <= timeout_nxt;
    end
  end

endmodule // rtsm_status_map

// [rtsm_monitor.sv]
// Checker of the status word, latch strobe and memory handshake.
// Assumes it is bound into rtsm_status_map and sees only its ports.
`timescale 1ns/100ps
module rtsm_check (
  input wire        clk_in, srst_in, status_valid_out, xfer_start_in, address_latch_strobe_out,
  input wire        message_error_in, service_request_in, broadcast_in, terminal_busy_in,
  input wire        subsystem_flag_in, terminal_flag_in, inhibit_terminal_flag_in_in,
  input wire        memory_grant_n_in, memory_request_n_out, mem_write_out, mem_timeout_out,
  input wire [4:0]  terminal_address_in,
  input wire [10:0] mem_addr_out,
  input wire [15:0] command_word_in, command_value_out, status_word_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_ad; status_valid_out |-> status_word_out[15:11] == $past(terminal_address_in); endproperty
  a_ad: assert property (p_ad) else $error("bad address field");
  property p_pin; status_valid_out |-> {status_word_out[10], status_word_out[8], status_word_out[3:2]}
    == $past({message_error_in, service_request_in, terminal_busy_in, subsystem_flag_in}); endproperty
  a_pin: assert property (p_pin) else $error("bad flag bits");
  // Broadcast seen at the start of the transfer, rebuilt from the ports.
  reg bcst_h;
  always @(posedge clk_in) bcst_h <= srst_in ? 1'b0 : (xfer_start_in ? broadcast_in : bcst_h);
  property p_bc; status_valid_out |-> status_word_out[4] == $past(bcst_h | broadcast_in); endproperty
  a_bc: assert property (p_bc) else $error("bad broadcast bit");
  property p_tmo; mem_timeout_out |-> $past(memory_grant_n_in) && memory_request_n_out; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout while granted");
  property p_zero; (status_word_out & 16'h02E2) == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("fixed bits set");
  property p_tf; status_valid_out |-> status_word_out[0] == $past(terminal_flag_in & ~inhibit_terminal_flag_in_in); endproperty
  a_tf: assert property (p_tf) else $error("bad terminal flag");
  property p_hold; !status_valid_out |-> $stable(status_word_out); endproperty
  a_hold: assert property (p_hold) else $error("status word moved");
  property p_lat; xfer_start_in |=> address_latch_strobe_out && command_value_out == $past(command_word_in); endproperty
  a_lat: assert property (p_lat) else $error("bad latch strobe");
  property p_wr; mem_write_out |-> $past(!memory_grant_n_in && !memory_request_n_out) ##1 memory_request_n_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write without grant");
  property p_map; mem_write_out |-> mem_addr_out == {command_value_out[10] ? 6'h1F : 6'h00, command_value_out[9:5]};
  endproperty
  a_map: assert property (p_map) else $error("bad memory address");
endmodule // rtsm_check
bind rtsm_status_map rtsm_check chk (.*);

// [rtsm_mem_model.sv]
// Backend memory answering each request with an active-low grant.
// Assumes the bench sets the grant delay in cycles.
`timescale 1ns/100ps
module rtsm_mem_model (
  input  wire        clk_in, req_n_in, wr_in,
  input  wire [10:0] addr_in,
  input  wire [15:0] wdata_in,
  input  wire [7:0]  delay_in,
  output reg         gnt_n_out = 1'b1
);
  reg [15:0] rx_r [0:1023], tx_r [0:1023];
  integer    cnt = 0;
  // Grant is registered, so it rises on the first edge that sees the request gone, one cycle after the request rises.
  always @(posedge clk_in) begin
    cnt <= req_n_in ? 0 : cnt + 1;
    // A delay of all ones stands for a backend that never grants.
    gnt_n_out <= req_n_in || cnt < delay_in || delay_in == 8'hFF;
    if (wr_in && addr_in[10]) tx_r[addr_in[9:0]] <= wdata_in;
    if (wr_in && !addr_in[10]) rx_r[addr_in[9:0]] <= wdata_in;
  end
endmodule // rtsm_mem_model

// [tb.sv]
// Bench: queue model of the memory writes and a direct expected value of the status word.
// Assumes rtsm_mem_model grants requests and rtsm_check is bound.
`timescale 1ns/100ps
module tb;
  reg        clk_in = 0, srst_in = 1, xfer_start_in = 0, xfer_end_in = 0, status_load_in = 0;
  reg        service_request_in = 0, terminal_busy_in = 0, subsystem_flag_in = 0, terminal_flag_in = 0;
  reg        message_error_in = 0, broadcast_in = 0, inhibit_terminal_flag_in_in = 0;
  reg        loopback_subaddress_select_in = 0;
  reg [4:0]  terminal_address_in = 0;
  reg [7:0]  dly = 0;
  reg [15:0] command_word_in = 0, transfer_status_word_in = 0, w, t, ew;
  wire       memory_grant_n_in, memory_request_n_out, mem_write_out, mem_timeout_out, int_req_out;
  wire       address_latch_strobe_out, vector_latch_strobe_out, status_valid_out;
  wire [6:0] int_vector_out;
  wire [10:0] mem_addr_out;
  wire [15:0] mem_wdata_out, command_value_out, status_word_out;
  integer    seed = 51375, error_cnt = 0, n_compared = 0, i, k, n_tmo = 0, n_vlat = 0;
  reg [26:0] exp_q [$];
  rtsm_status_map uut (.*);
  rtsm_mem_model mem (.clk_in, .req_n_in(memory_request_n_out), .wr_in(mem_write_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .delay_in(dly), .gnt_n_out(memory_grant_n_in));
  initial forever #10 clk_in = ~clk_in;
  initial begin
    repeat (30000) @(posedge clk_in);
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  task cmp(input [26:0] got, input [26:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) if (mem_write_out === 1'b1) cmp({mem_addr_out, mem_wdata_out}, exp_q.pop_front());
  always @(posedge clk_in) begin
    if (mem_timeout_out === 1'b1) n_tmo = n_tmo + 1;
    if (vector_latch_strobe_out === 1'b1) n_vlat = n_vlat + 1;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 0;
    // Subaddresses 0 and 31 first; odd passes end the transfer back to back.
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk_in);
      w = ($random(seed) & (i == 0 ? 16'hFC1F : 16'hFFFF)) | (i == 1 ? 16'h03E0 : 16'h0000);
      t = $random(seed);
      command_word_in <= w;
      transfer_status_word_in <= t;
      xfer_start_in <= 1;
      dly <= i == 7 ? 8'hC8 : $random(seed) & 8'h07;
      exp_q.push_back({w[10] ? 6'h1F : 6'h00, w[9:5], w});
      exp_q.push_back({w[10] ? 6'h1F : 6'h00, w[9:5], t});
      @(posedge clk_in);
      xfer_start_in <= 0;
      repeat (i % 2 ? 0 : 3) @(posedge clk_in);
      xfer_end_in <= 1;
      @(posedge clk_in);
      xfer_end_in <= 0;
      for (k = 0; k < 900 && exp_q.size() > 0; k = k + 1) @(posedge clk_in);
      cmp(exp_q.size(), 0);
      cmp(command_value_out, w);
      cmp(int_vector_out, {1'b0, w[10:5]});
      cmp(int_req_out, 1'b1);
    end
    // A backend that never grants: both writes time out and nothing lands.
    @(posedge clk_in);
    dly <= 8'hFF;
    command_word_in <= 16'h0420;
    xfer_start_in <= 1;
    @(posedge clk_in);
    xfer_start_in <= 0;
    xfer_end_in <= 1;
    @(posedge clk_in);
    xfer_end_in <= 0;
    repeat (1300) @(posedge clk_in);
    cmp(n_tmo, 2);
    cmp(exp_q.size(), 0);
    cmp(n_vlat, 9);
    dly <= 0;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk_in);
      w = $random(seed);
      {terminal_address_in, service_request_in, terminal_busy_in, subsystem_flag_in, terminal_flag_in,
        message_error_in, broadcast_in, inhibit_terminal_flag_in_in} <= w[11:0];
      status_load_in <= 1;
      ew = {w[11:7], w[2], 1'b0, w[6], 3'h0, w[1], w[5:4], 1'b0, w[3] & ~w[0]};
      @(posedge clk_in);
      status_load_in <= 0;
      terminal_address_in <= ~w[11:7];
      service_request_in <= ~w[6];
      repeat (2) @(posedge clk_in);
      cmp(status_word_out, ew);
    end
    print_verdict;
  end
endmodule // tb
